/* File: rtl/cptc_map.vh */
`ifndef CPTC_MAP_VH
`define CPTC_MAP_VH
// ----------------------------------------
// Register map
// ----------------------------------------
`define CPTC_OFS_CTRL0        12'h0d4
`define CPTC_OFS_PROBE_STAT   12'h0d8
`define CPTC_OFS_LIMIT        12'h0dc
`define CPTC_OFS_PLL_STAT     12'h0e0
// ----------------------------------------
// Field positions
// ----------------------------------------
`define CPTC_BIT_OVR          18
`define CPTC_LOCK_HI          17
`define CPTC_LOCK_LO          16
`define CPTC_HOLD_HI          11
`define CPTC_HOLD_LO          8
`define CPTC_BIT_FEN          6
`define CPTC_CODE_HI          5
`define CPTC_CODE_LO          0
// Writable bits of the control register
`define CPTC_CTRL0_WMASK      32'h0007_0f7f
// ----------------------------------------
// Reset values
// ----------------------------------------
`define CPTC_RST_OVR          1'h0
`define CPTC_RST_LOCK         2'h0
`define CPTC_RST_HOLD         4'h0
`define CPTC_RST_FEN          1'h1
`define CPTC_RST_LIMIT        6'h00
// ----------------------------------------
// Timing
// ----------------------------------------
`define CPTC_CLK_MHZ          125
`define CPTC_LOCK_US_0        1
`define CPTC_LOCK_US_1        10
`define CPTC_LOCK_US_2        100
`define CPTC_LOCK_US_3        1000
`define CPTC_HOLD_UNIT_NS     320
`define CPTC_CLK_PERIOD_NS    8
`define CPTC_FREQ_STEP_MHZ    100
`define CPTC_FREQ_OFFSET      6'h08
`define CPTC_FREQ_DEFAULT_MHZ 13'h0640
`endif

/* File: rtl/cptc_timer.v */
`timescale 1ns/1ps
// ----------------------------------------
// Down counter with restart
// ----------------------------------------
module cptc_timer #(
  parameter WIDTH = 20
) (
  // Clock and reset
  input  wire             clock,
  input  wire             resetn,
  // Control
  input  wire             start,
  input  wire [WIDTH-1:0] load,
  // Status
  output wire             busy,
  output wire             done
);
  reg [WIDTH-1:0] count;
  reg             done_q;

  always @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      count  <= {WIDTH{1'b0}};
      done_q <= 1'b0;
    end else if (start) begin
      count  <= load;
      done_q <= 1'b0;
    end else if (count != {WIDTH{1'b0}}) begin
      count  <= count - {{(WIDTH-1){1'b0}}, 1'b1};
      done_q <= (count == {{(WIDTH-1){1'b0}}, 1'b1});
    end else begin
      done_q <= 1'b0;
    end
  end

  assign busy = (count != {WIDTH{1'b0}});
  assign done = done_q;
endmodule // cptc_timer

/* File: rtl/cptc_top.v */
// How it works
// - Override bit set selects alternate per-state settings, clear selects legacy C1 byte.
// - Lock field 00/01/10/11 selects 1, 10, 100, 1000 us.
// - Frequency-changing reconnect waits until the selected lock time elapses.
// - Probe request during halt or stop-grant raises the core clock.
// - Each probe during halt or stop-grant restarts hysteresis; clock lowers after quiet full period.
// - Hysteresis period is 320 ns times one plus the field.
// - Frequency enable decides whether the code sets the PLL after reset.
// - Enable clear runs the PLL at 1.6 GHz regardless of code.
// - Code and enable writable anytime, applied only at next warm reset.
// - PLL frequency is 100 MHz times code plus 08h.
// - Zero limit means no limit; otherwise codes above limit clamp.
//
// Chosen here: the APB register port.
`timescale 1ns/1ps
`include "cptc_map.vh"
module cptc_top #(
  parameter [5:0] CODE_COLD_RESET = 6'h08,
  parameter       LOCK_WIDTH      = 17
) (
  // Clock and reset
  input  wire        clock,
  input  wire        resetn,
  input  wire        warm_resetn,
  // APB slave
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output wire        pready,
  output reg  [31:0] prdata,
  output wire        pslverr,
  // Power state inputs from core
  input  wire        core_halt_or_stopgrant,
  input  wire        probe_request,
  input  wire [7:0]  legacy_c1_action,
  input  wire [2:0]  alt_state_core_divisor_in,
  input  wire        alt_state_alt_voltage_enable_in,
  input  wire        alt_state_memclk_tristate_in,
  input  wire        alt_state_dram_self_refresh_in,
  input  wire        alt_state_probe_enable_in,
  // Effective low-power settings
  output reg         c1_action_override_disable,
  output reg  [7:0]  c1_action_eff,
  output reg  [2:0]  alt_state_core_divisor,
  output reg         alt_state_alt_voltage_enable,
  output reg         alt_state_memclk_tristate,
  output reg         alt_state_dram_self_refresh,
  output reg         alt_state_probe_enable,
  // Link reconnect
  input  wire        reconnect_request,
  input  wire        link_freq_change,
  output reg         reconnect_go,
  output wire        link_pll_locking,
  // Core clock
  output reg         core_clock_raise,
  // Main PLL
  output reg  [5:0]  main_pll_code_applied,
  output reg  [12:0] main_pll_freq_mhz
);
  // ----------------------------------------
  // Input synchronisers
  // ----------------------------------------
  reg [1:0] sync_halt;
  reg [1:0] sync_probe;
  reg [1:0] sync_req;
  reg [1:0] sync_chg;
  reg [1:0] sync_warm;
  reg       probe_q;
  reg       req_q;
  wire      halt_s  = sync_halt[1];
  wire      probe_s = sync_probe[1];
  wire      req_s   = sync_req[1];
  wire      chg_s   = sync_chg[1];
  wire      warm_s  = sync_warm[1];
  wire      probe_evt = probe_s & ~probe_q;
  wire      req_evt   = req_s & ~req_q;

  always @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      sync_halt  <= 2'h0;
      sync_probe <= 2'h0;
      sync_req   <= 2'h0;
      sync_chg   <= 2'h0;
      sync_warm  <= 2'h3;
      probe_q    <= 1'b0;
      req_q      <= 1'b0;
    end else begin
      sync_halt  <= {sync_halt[0], core_halt_or_stopgrant};
      sync_probe <= {sync_probe[0], probe_request};
      sync_req   <= {sync_req[0], reconnect_request};
      sync_chg   <= {sync_chg[0], link_freq_change};
      sync_warm  <= {sync_warm[0], warm_resetn};
      probe_q    <= probe_s;
      req_q      <= req_s;
    end
  end

  // ----------------------------------------
  // Register file
  // ----------------------------------------
  reg        ovr;
  reg [1:0]  lock_sel;
  reg [3:0]  hold_sel;
  reg        fen;
  reg [5:0]  code;
  reg [5:0]  code_limit;
  reg        warm_q;
  reg        code_loaded;
  wire       wr = psel & penable & pwrite;
  wire       hit_ctrl  = (paddr == `CPTC_OFS_CTRL0);
  wire       hit_limit = (paddr == `CPTC_OFS_LIMIT);
  wire       hit_pstat = (paddr == `CPTC_OFS_PROBE_STAT);
  wire       hit_pll   = (paddr == `CPTC_OFS_PLL_STAT);
  wire       mapped    = hit_ctrl | hit_limit | hit_pstat | hit_pll;
  wire [31:0] wmask_d  = pwdata & `CPTC_CTRL0_WMASK;

  assign pready  = 1'b1;
  assign pslverr = psel & penable & ~mapped;

  always @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      ovr        <= `CPTC_RST_OVR;
      lock_sel   <= `CPTC_RST_LOCK;
      hold_sel   <= `CPTC_RST_HOLD;
      fen        <= `CPTC_RST_FEN;
      code       <= 6'h00;
      code_limit <= `CPTC_RST_LIMIT;
    end else begin
      if (wr && hit_ctrl) begin
        ovr      <= wmask_d[`CPTC_BIT_OVR];
        lock_sel <= wmask_d[`CPTC_LOCK_HI:`CPTC_LOCK_LO];
        hold_sel <= wmask_d[`CPTC_HOLD_HI:`CPTC_HOLD_LO];
        fen      <= wmask_d[`CPTC_BIT_FEN];
        code     <= wmask_d[`CPTC_CODE_HI:`CPTC_CODE_LO];
      end else if (!code_loaded) begin
        code     <= CODE_COLD_RESET;
      end
      if (wr && hit_limit) begin
        code_limit <= pwdata[`CPTC_CODE_HI:`CPTC_CODE_LO];
      end
    end
  end

  // ----------------------------------------
  // Cold-reset product code
  // ----------------------------------------
  always @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      code_loaded <= 1'b0;
    end else begin
      code_loaded <= 1'b1;
    end
  end

  // ----------------------------------------
  // Read data
  // ----------------------------------------
  reg [31:0] rd_word;
  always @* begin
    rd_word = 32'h0000_0000;
    if (hit_ctrl) begin
      rd_word[`CPTC_BIT_OVR]                = ovr;
      rd_word[`CPTC_LOCK_HI:`CPTC_LOCK_LO] = lock_sel;
      rd_word[`CPTC_HOLD_HI:`CPTC_HOLD_LO] = hold_sel;
      rd_word[`CPTC_BIT_FEN]                = fen;
      rd_word[`CPTC_CODE_HI:`CPTC_CODE_LO] = code;
    end else if (hit_limit) begin
      rd_word[`CPTC_CODE_HI:`CPTC_CODE_LO] = code_limit;
    end else if (hit_pstat) begin
      rd_word[0] = core_clock_raise;
      rd_word[1] = link_pll_locking;
    end else if (hit_pll) begin
      rd_word[`CPTC_CODE_HI:`CPTC_CODE_LO] = main_pll_code_applied;
    end
  end

  always @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      prdata <= rd_word;
    end
  end

  // ----------------------------------------
  // Low-power setting selection
  // ----------------------------------------
  always @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      c1_action_override_disable   <= 1'b0;
      c1_action_eff                <= 8'h00;
      alt_state_core_divisor       <= 3'h0;
      alt_state_alt_voltage_enable <= 1'b0;
      alt_state_memclk_tristate    <= 1'b0;
      alt_state_dram_self_refresh  <= 1'b0;
      alt_state_probe_enable       <= 1'b0;
    end else begin
      c1_action_override_disable   <= ovr;
      c1_action_eff                <= ovr ? 8'h00 : legacy_c1_action;
      alt_state_core_divisor       <= ovr ? alt_state_core_divisor_in : 3'h0;
      alt_state_alt_voltage_enable <= ovr & alt_state_alt_voltage_enable_in;
      alt_state_memclk_tristate    <= ovr & alt_state_memclk_tristate_in;
      alt_state_dram_self_refresh  <= ovr & alt_state_dram_self_refresh_in;
      alt_state_probe_enable       <= ovr & alt_state_probe_enable_in;
    end
  end

  // ----------------------------------------
  // Link PLL lock delay
  // ----------------------------------------
  function [LOCK_WIDTH-1:0] lock_cycles;
    input [1:0]  sel;
    reg   [31:0] full;
    begin
      case (sel)
        2'h0:    full = `CPTC_LOCK_US_0 * `CPTC_CLK_MHZ;
        2'h1:    full = `CPTC_LOCK_US_1 * `CPTC_CLK_MHZ;
        2'h2:    full = `CPTC_LOCK_US_2 * `CPTC_CLK_MHZ;
        default: full = `CPTC_LOCK_US_3 * `CPTC_CLK_MHZ;
      endcase
      lock_cycles = full[LOCK_WIDTH-1:0];
    end
  endfunction

  // ----------------------------------------
  // Reconnect sequencer
  // ----------------------------------------
  localparam [2:0] RC_IDLE = 3'b001;
  localparam [2:0] RC_WAIT = 3'b010;
  localparam [2:0] RC_GO   = 3'b100;
  reg  [2:0] rc_state;
  reg  [2:0] next_rc_state;
  wire       lock_start = (rc_state == RC_IDLE) & req_evt & chg_s;
  wire       lock_done;

  // ----------------------------------------
  // Lock timer
  // ----------------------------------------
  cptc_timer #(.WIDTH(LOCK_WIDTH)) u_lock (
    .clock  (clock),
    .resetn (resetn),
    .start  (lock_start),
    .load   (lock_cycles(lock_sel)),
    .busy   (link_pll_locking),
    .done   (lock_done)
  );

  always @* begin
    next_rc_state = rc_state;
    case (rc_state)
      RC_IDLE: begin
        if (req_evt) begin
          next_rc_state = chg_s ? RC_WAIT : RC_GO;
        end
      end
      RC_WAIT: begin
        if (lock_done) begin
          next_rc_state = RC_GO;
        end
      end
      RC_GO:   next_rc_state = RC_IDLE;
      default: next_rc_state = RC_IDLE;
    endcase
  end

  always @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      rc_state     <= RC_IDLE;
      reconnect_go <= 1'b0;
    end else begin
      rc_state     <= next_rc_state;
      reconnect_go <= (next_rc_state == RC_GO);
    end
  end

  // ----------------------------------------
  // Core clock hysteresis
  // ----------------------------------------
  function [9:0] hold_cycles;
    input [3:0]  sel;
    reg   [31:0] full;
    begin
      full        = ({28'h0, sel} + 32'h0000_0001) * (`CPTC_HOLD_UNIT_NS / `CPTC_CLK_PERIOD_NS);
      hold_cycles = full[9:0];
    end
  endfunction

  reg [9:0] hold_count;
  always @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      hold_count       <= 10'h000;
      core_clock_raise <= 1'b0;
    end else if (probe_evt && halt_s) begin
      hold_count       <= hold_cycles(hold_sel);
      core_clock_raise <= 1'b1;
    end else if (hold_count > 10'h001) begin
      hold_count       <= hold_count - 10'h001;
    end else begin
      hold_count       <= 10'h000;
      core_clock_raise <= 1'b0;
    end
  end

  // ----------------------------------------
  // Main PLL frequency, taken at warm reset
  // ----------------------------------------
  function [5:0] clamp_code;
    input [5:0] c;
    input [5:0] lim;
    begin
      clamp_code = ((lim != 6'h00) && (c > lim)) ? lim : c;
    end
  endfunction

  function [12:0] pll_freq;
    input [5:0]  c;
    input        en;
    reg   [31:0] full;
    begin
      full     = ({26'h0, c} + {26'h0, `CPTC_FREQ_OFFSET}) * `CPTC_FREQ_STEP_MHZ;
      pll_freq = en ? full[12:0] : `CPTC_FREQ_DEFAULT_MHZ;
    end
  endfunction

  wire [5:0] code_src = code_loaded ? code : CODE_COLD_RESET;
  wire [5:0] code_eff = clamp_code(code_src, code_limit);

  // ----------------------------------------
  // Applied code and frequency
  // ----------------------------------------
  always @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      warm_q                <= 1'b1;
      main_pll_code_applied <= 6'h00;
      main_pll_freq_mhz     <= `CPTC_FREQ_DEFAULT_MHZ;
    end else begin
      warm_q <= warm_s;
      if ((warm_s && !warm_q) || !code_loaded) begin
        main_pll_code_applied <= code_eff;
        main_pll_freq_mhz     <= pll_freq(code_eff, fen);
      end
    end
  end
endmodule // cptc_top

/* File: verif/cptc_chk.sv */
`timescale 1ns/1ps
// --------
// Checker
// --------
module cptc_chk (
  // Clock and reset
  input wire        clock,
  input wire        resetn,
  input wire        warm_resetn,
  // Watched
  input wire        probe_request,
  input wire        c1_action_override_disable,
  input wire [7:0]  c1_action_eff,
  input wire        reconnect_go,
  input wire        link_pll_locking,
  input wire        core_clock_raise,
  input wire [5:0]  main_pll_code_applied,
  input wire [12:0] main_pll_freq_mhz
);
  reg [3:0]  warm_age;
  reg [10:0] probe_age;
  default clocking cb @(posedge clock); endclocking
  default disable iff (!resetn);
  always @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      warm_age  <= 4'h0;
      probe_age <= 11'h0;
    end else begin
      warm_age  <= warm_resetn ? warm_age + {3'h0, warm_age != 4'hf} : 4'h0;
      probe_age <= $rose(probe_request) ? 11'h0 : probe_age + {10'h0, probe_age != 11'h7ff};
    end
  end
  sequence s_steady;
    $stable(c1_action_override_disable);
  endsequence
  a_legacy_blocked: assert property (s_steady ##0 c1_action_override_disable |-> c1_action_eff == 8'h00)
    else $error("legacy action passed");
  a_go_pulse: assert property (reconnect_go |=> !reconnect_go)
    else $error("reconnect pulse too long");
  a_lock_min: assert property ($rose(link_pll_locking) |-> link_pll_locking [*8])
    else $error("lock wait too short");
  a_raise_cause: assert property ($rose(core_clock_raise) |-> probe_age <= 11'h8)
    else $error("clock raised without probe");
  a_raise_min: assert property ($rose(core_clock_raise) |-> core_clock_raise [*8])
    else $error("clock dropped early");
  a_hold_span: assert property ($fell(core_clock_raise) |-> probe_age >= 11'h28 && probe_age <= 11'h290)
    else $error("hold period wrong");
  a_warm_apply: assert property ($changed(main_pll_code_applied) |-> warm_age < 4'h8)
    else $error("code applied outside warm reset");
  a_freq_map: assert property (main_pll_freq_mhz == 13'h0640 ||
    main_pll_freq_mhz == ({7'h00, main_pll_code_applied} + 13'h0008) * 13'h0064) else $error("frequency mismatch");
endmodule // cptc_chk
bind cptc_top cptc_chk u_chk (.clock(clock), .resetn(resetn), .warm_resetn(warm_resetn),
  .probe_request(probe_request), .c1_action_override_disable(c1_action_override_disable),
  .c1_action_eff(c1_action_eff), .reconnect_go(reconnect_go), .link_pll_locking(link_pll_locking),
  .core_clock_raise(core_clock_raise), .main_pll_code_applied(main_pll_code_applied),
  .main_pll_freq_mhz(main_pll_freq_mhz));

/* File: verif/cptc_tb_top.sv */
`timescale 1ns/1ps
// --------
// Bench
// --------
module cptc_tb_top;
  reg         clock, resetn, warm_resetn, psel, penable, pwrite, halt, probe, recon, fchg, rerr;
  reg  [11:0] paddr;
  reg  [31:0] pwdata, rdat;
  reg  [7:0]  legacy;
  reg  [6:0]  alt_in;
  reg  [3:0]  sel;
  wire        pready, pslverr, go, raise, ovr_seen, locking;
  wire [5:0]  applied;
  wire [31:0] prdata;
  wire [7:0]  eff;
  wire [6:0]  alt;
  wire [12:0] freq;
  integer     error_cnt, num_checks, seed, fq, i, n, up, lk, c, d, lim;
  cptc_top uut (.clock(clock), .resetn(resetn), .warm_resetn(warm_resetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .core_halt_or_stopgrant(halt), .probe_request(probe), .legacy_c1_action(legacy),
    .alt_state_core_divisor_in(alt_in[2:0]), .alt_state_alt_voltage_enable_in(alt_in[3]),
    .alt_state_memclk_tristate_in(alt_in[4]), .alt_state_dram_self_refresh_in(alt_in[5]),
    .alt_state_probe_enable_in(alt_in[6]), .c1_action_override_disable(ovr_seen), .c1_action_eff(eff),
    .alt_state_core_divisor(alt[2:0]), .alt_state_alt_voltage_enable(alt[3]),
    .alt_state_memclk_tristate(alt[4]), .alt_state_dram_self_refresh(alt[5]),
    .alt_state_probe_enable(alt[6]), .reconnect_request(recon), .link_freq_change(fchg),
    .reconnect_go(go), .link_pll_locking(locking), .core_clock_raise(raise),
    .main_pll_code_applied(applied), .main_pll_freq_mhz(freq));
  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end
  initial begin
    #400000;
    error_cnt = error_cnt + 1;
    complete_run;
  end
  task chk(input [63:0] nm, input [31:0] e, input [31:0] g);
    begin
      num_checks = num_checks + 1;
      if (g !== e) begin
        error_cnt = error_cnt + 1;
        $display("Error %0s exp %h got %h", nm, e, g);
      end
    end
  endtask
  task apb(input w, input [11:0] a, input [31:0] dat);
    begin
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= dat;
      @(posedge clock);
      penable <= 1'b1;
      @(posedge clock);
      while (pready !== 1'b1) begin
        @(posedge clock);
      end
      rdat = prdata;
      rerr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clock);
    end
  endtask
  task pulse;
    begin
      probe <= 1'b1;
      @(posedge clock);
      probe <= 1'b0;
    end
  endtask
  task complete_run;
    begin
      $display("checks %0d errors %0d", num_checks, error_cnt);
      if (error_cnt == 0 && num_checks > 0)
        $display("bench passed");
      else
        $display("bench failed");
      $finish;
    end
  endtask
  initial begin
    {resetn, psel, penable, pwrite, halt, probe, recon, fchg, warm_resetn} = 9'h001;
    paddr = 12'h000;
    pwdata = 32'h0;
    legacy = 8'h00;
    alt_in = 7'h00;
    error_cnt = 0;
    num_checks = 0;
    seed = 32'hfe5b74d3;
    repeat (12) @(posedge clock);
    resetn <= 1'b1;
    repeat (2) @(posedge clock);
    apb(1'b0, 12'h0d4, 0);
    chk("ctrl", 32'h48, rdat);
    chk("freq", 1600, freq);
    apb(1'b1, 12'h0d4, 32'hffffffff);
    apb(1'b0, 12'h0d4, 0);
    chk("ctrl", 32'h70f7f, rdat);
    apb(1'b0, 12'h0f0, 0);
    chk("unmapped", 1, rerr);
    // Override on and off, reserved bit 19 too
    for (i = 0; i < 4; i = i + 1) begin
      apb(1'b1, 12'h0d4, i << 18);
      legacy <= $random(seed);
      alt_in <= $random(seed);
      repeat (3) @(posedge clock);
      chk("legacy", i[0] ? 0 : legacy, eff);
      chk("alt", i[0] ? alt_in : 0, alt);
      chk("ovr", i[0], ovr_seen);
    end
    // Probe hold: restart, running cores, longest period
    for (i = 0; i < 3; i = i + 1) begin
      sel = i[1] ? 4'hf : $random(seed);
      apb(1'b1, 12'h0d4, {20'h0, sel, 8'h0});
      halt <= i != 1;
      repeat (4) @(posedge clock);
      pulse;
      if (i == 0) begin
        repeat (20) @(posedge clock);
        chk("held", 1, raise);
        apb(1'b0, 12'h0d8, 0);
        chk("pstat", 1, rdat);
        pulse;
      end
      n = 0;
      up = 0;
      while (n < 700 && (n < 8 || raise === 1'b1)) begin
        @(posedge clock);
        n = n + 1;
        up = up | raise;
      end
      chk("raised", i != 1, up);
      if (i != 1) chk("hold", 1, n >= (sel + 1) * 40 && n <= (sel + 1) * 40 + 8);
    end
    // Reconnect with lock codes 0..2, then without frequency change
    for (i = 0; i < 4; i = i + 1) begin
      apb(1'b1, 12'h0d4, (i % 3) << 16);
      fchg <= i < 3;
      repeat (4) @(posedge clock);
      recon <= 1'b1;
      n = 0;
      up = 0;
      while (go !== 1'b1 && n < 20000) begin
        @(posedge clock);
        n = n + 1;
        up = up + locking;
      end
      recon <= 1'b0;
      lk = i < 3 ? 125 * 10 ** i : 0;
      chk("lock", 1, n >= lk && n <= lk + 12);
      chk("locking", lk, up);
    end
    // Frequency code, enable and limit through warm reset
    fq = 1600;
    for (i = 0; i < 4; i = i + 1) begin
      d = i == 0 ? 32'h10 : i == 1 ? 32'h40 | ($random(seed) & 63) : i == 2 ? 32'h5f : 32'h45;
      lim = i < 2 ? 0 : i + 2;
      apb(1'b1, 12'h0dc, lim);
      apb(1'b1, 12'h0d4, d);
      chk("freq", fq, freq);
      warm_resetn <= 1'b0;
      repeat (4) @(posedge clock);
      warm_resetn <= 1'b1;
      repeat (8) @(posedge clock);
      c = lim != 0 && d[5:0] > lim ? lim : d[5:0];
      fq = d[6] ? (c + 8) * 100 : 1600;
      chk("freq", fq, freq);
      chk("code", c, applied);
      apb(1'b0, 12'h0e0, 0);
      chk("pllreg", c, rdat);
    end
    complete_run;
  end
endmodule // cptc_tb_top
